/* File: daoc_pkg.sv */
package daoc_pkg;

  // ----------------------------------------
  // sample format and latency
  // ----------------------------------------
  localparam int SAMPLE_W = 8;
  localparam int LATENCY_CYCLES = 5;
  localparam int CONV_DIV_DEF = 1;
  localparam logic [7:0] MID_CODE = 8'h80;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int ADR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] DATA_OFS = 8'h08;

  // ctrl field positions
  localparam int CTRL_FMT_BIT = 0;
  localparam int CTRL_SLEEP_BIT = 1;
  localparam int CTRL_PD_BIT = 2;
  localparam int CTRL_OEN_BIT = 3;

  // stat field positions
  localparam int STAT_OE_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  localparam int STAT_SLEEP_BIT = 2;
  localparam int STAT_PD_BIT = 3;

  // data field positions
  localparam int DATA_A_LSB = 0;
  localparam int DATA_B_LSB = 8;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic output_enable_n;
    logic power_down_request;
    logic sleep;
    logic fmt_twos;
  } daoc_ctrl_s;

  localparam daoc_ctrl_s CTRL_RST = '{output_enable_n: 1'b1, power_down_request: 1'b0,
                                      sleep: 1'b0, fmt_twos: 1'b0};

  typedef struct packed {
    logic [7:0] chan_b;
    logic [7:0] chan_a;
  } daoc_pair_s;

  // offset binary to the selected output code
  function automatic logic [7:0] daoc_fmt(input logic [7:0] raw, input logic twos);
    daoc_fmt = twos ? {~raw[7], raw[6:0]} : raw;
  endfunction

endpackage

/* File: daoc_tick_div.sv */
`timescale 1ns/1ps
module daoc_tick_div #(
  parameter int DIV = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic tick_o
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic tick_q;
  logic tick_d;

  always_comb
  begin
    tick_d = (cnt_q == LAST);
    cnt_d = tick_d ? '0 : cnt_q + CW'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

  tick_period_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (DIV == 1) |-> ##1 tick_o)
    else $error("divide by one must tick every cycle");

endmodule // daoc_tick_div

/* File: daoc_pipe.sv */
`timescale 1ns/1ps
module daoc_pipe #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 5,
  parameter logic [WIDTH-1:0] FLUSH_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic adv_i,
  input wire logic flush_i,
  input wire logic [WIDTH-1:0] din_i,
  output logic [WIDTH-1:0] dout_o
);

  logic [WIDTH-1:0] stage_q [DEPTH];
  logic [WIDTH-1:0] stage_d [DEPTH];

  // ----------------------------------------
  // one register per converter clock of latency
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_stage
      always_comb
      begin
        if (flush_i)
          stage_d[g] = FLUSH_VAL;
        else if (adv_i)
          stage_d[g] = (g == 0) ? din_i : stage_q[(g == 0) ? 0 : g - 1];
        else
          stage_d[g] = stage_q[g];
      end

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          stage_q[g] <= FLUSH_VAL;
        else
          stage_q[g] <= stage_d[g];
      end
    end
  endgenerate

  assign dout_o = stage_q[DEPTH-1];

  pipe_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!adv_i && !flush_i) |=> $stable(dout_o))
    else $error("pipe moved without advance");

endmodule // daoc_pipe

/* File: daoc_top.sv */
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
// Operation
// RQ1: output words are two's complement when the format bit is high, offset binary when low.
// RQ2: sleep high stops both quantizers while the bias stays up; sleep low runs normally.
// RQ3: power-down high puts the block in power-down, low returns it to conversion.
// RQ4: the active-low output enable drives both buses when low and releases them when high.
// RQ5: each channel has its own 8-bit three-state bus, bit 7 the msb and bit 0 the lsb.
// RQ6: both channels are sampled on the same rising converter clock edge.
// RQ7: each word appears five converter clocks after the edge that sampled it.
// RQ8: bipolar zero is 1000 0000 in offset binary and 0000 0000 in two's complement.
module daoc_top #(
  parameter int CONV_DIV = daoc_pkg::CONV_DIV_DEF,
  parameter int LATENCY = daoc_pkg::LATENCY_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [daoc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] chan_a_quant_i,
  input wire logic [7:0] chan_b_quant_i,
  output logic [7:0] chan_a_sample_bus_o,
  output logic [7:0] chan_a_sample_bus_oe_o,
  output logic [7:0] chan_b_sample_bus_o,
  output logic [7:0] chan_b_sample_bus_oe_o
);

  // ----------------------------------------
  // converter clock enable
  // ----------------------------------------
  logic conv_tick;

  daoc_tick_div #(
    .DIV(CONV_DIV)
  ) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(conv_tick)
  );

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  daoc_pkg::daoc_ctrl_s ctrl_q;
  daoc_pkg::daoc_ctrl_s ctrl_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic bus_req;
  logic wr_fire;
  logic [31:0] rdata;

  // shared offset decode for the write path, the read mux and the checks
  function automatic logic adr_hit(
    input logic [daoc_pkg::ADR_W-1:0] adr,
    input logic [daoc_pkg::ADR_W-1:0] ofs
  );
    adr_hit = (adr == ofs);
  endfunction

  // ----------------------------------------
  // converter state
  // ----------------------------------------
  daoc_pkg::daoc_pair_s quant_pair;
  daoc_pkg::daoc_pair_s pipe_pair;
  daoc_pkg::daoc_pair_s word_q;
  daoc_pkg::daoc_pair_s word_d;
  daoc_pkg::daoc_pair_s raw_q;
  daoc_pkg::daoc_pair_s raw_d;
  logic oe_q;
  logic oe_d;
  logic running;
  logic advance;
  logic flush;
  logic update;

  // streak of unbroken advances, for the latency check
  localparam int SW = $clog2(LATENCY + 2);
  localparam logic [SW-1:0] STREAK_FULL = SW'(LATENCY + 1);
  logic [SW-1:0] streak_q;
  logic [SW-1:0] streak_d;

  // ----------------------------------------
  // bus handshake and control register
  // ----------------------------------------
  // one wait state: ack rises the cycle after the request, for one cycle
  assign bus_req = wb_cyc_i & wb_stb_i;
  // the write lands on the edge that sees ack high, as the master expects
  assign wr_fire = bus_req & wb_we_i & ack_q;

  always_comb
  begin
    rdata = '0;
    if (adr_hit(wb_adr_i, daoc_pkg::CTRL_OFS))
    begin
      rdata[daoc_pkg::CTRL_FMT_BIT] = ctrl_q.fmt_twos;
      rdata[daoc_pkg::CTRL_SLEEP_BIT] = ctrl_q.sleep;
      rdata[daoc_pkg::CTRL_PD_BIT] = ctrl_q.power_down_request;
      rdata[daoc_pkg::CTRL_OEN_BIT] = ctrl_q.output_enable_n;
    end
    else if (adr_hit(wb_adr_i, daoc_pkg::STAT_OFS))
    begin
      rdata[daoc_pkg::STAT_OE_BIT] = oe_q;
      rdata[daoc_pkg::STAT_RUN_BIT] = running;
      rdata[daoc_pkg::STAT_SLEEP_BIT] = ctrl_q.sleep;
      rdata[daoc_pkg::STAT_PD_BIT] = ctrl_q.power_down_request;
    end
    else if (adr_hit(wb_adr_i, daoc_pkg::DATA_OFS))
    begin
      rdata[daoc_pkg::DATA_A_LSB +: 8] = word_q.chan_a;
      rdata[daoc_pkg::DATA_B_LSB +: 8] = word_q.chan_b;
    end
  end

  always_comb
  begin
    ack_d = bus_req & ~ack_q;
    dat_d = ack_d ? rdata : dat_q;
    ctrl_d = ctrl_q;
    if (wr_fire && wb_sel_i[0] && adr_hit(wb_adr_i, daoc_pkg::CTRL_OFS))
    begin
      ctrl_d.fmt_twos = wb_dat_i[daoc_pkg::CTRL_FMT_BIT]; // RQ1
      ctrl_d.sleep = wb_dat_i[daoc_pkg::CTRL_SLEEP_BIT]; // RQ2
      ctrl_d.power_down_request = wb_dat_i[daoc_pkg::CTRL_PD_BIT]; // RQ3
      ctrl_d.output_enable_n = wb_dat_i[daoc_pkg::CTRL_OEN_BIT]; // RQ4
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= '0;
      ctrl_q <= daoc_pkg::CTRL_RST;
    end
    else
    begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ----------------------------------------
  // conversion pipeline
  // ----------------------------------------
  // sleep freezes the quantizers; power-down also drops what the pipe held
  assign running = ~ctrl_q.sleep & ~ctrl_q.power_down_request; // RQ2 RQ3
  assign advance = conv_tick & running;
  assign flush = ctrl_q.power_down_request; // RQ3
  assign update = conv_tick & (running | flush);

  // both quantizer words enter on the same converter edge
  assign quant_pair.chan_a = chan_a_quant_i; // RQ6
  assign quant_pair.chan_b = chan_b_quant_i; // RQ6

  // sampling register plus four stages; the output latch makes the fifth clock
  // a divided converter clock counts latency in ticks, not system clocks
  daoc_pipe #(
    .WIDTH($bits(daoc_pkg::daoc_pair_s)),
    .DEPTH(LATENCY),
    .FLUSH_VAL({daoc_pkg::MID_CODE, daoc_pkg::MID_CODE})
  ) u_pipe (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .adv_i(advance),
    .flush_i(flush),
    .din_i(quant_pair),
    .dout_o(pipe_pair)
  );

  // ----------------------------------------
  // output latch and drivers
  // ----------------------------------------
  always_comb
  begin
    word_d = word_q;
    raw_d = raw_q;
    if (update)
    begin
      raw_d = pipe_pair; // RQ7
      word_d.chan_a = daoc_pkg::daoc_fmt(pipe_pair.chan_a, ctrl_q.fmt_twos); // RQ1 RQ8
      word_d.chan_b = daoc_pkg::daoc_fmt(pipe_pair.chan_b, ctrl_q.fmt_twos); // RQ1 RQ8
    end
    // enable follows the pin level alone, not sleep or power-down
    oe_d = ~ctrl_q.output_enable_n; // RQ4
    // a gap in advances breaks sample alignment, so start over
    if (!advance)
      streak_d = '0;
    else if (streak_q != STREAK_FULL)
      streak_d = streak_q + SW'(1);
    else
      streak_d = streak_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      word_q <= '0;
      raw_q <= '0;
      oe_q <= 1'b0;
      streak_q <= '0;
    end
    else
    begin
      word_q <= word_d;
      raw_q <= raw_d;
      oe_q <= oe_d;
      streak_q <= streak_d;
    end
  end

  // each channel keeps its own bus, bit 7 the msb
  assign chan_a_sample_bus_o = word_q.chan_a; // RQ5
  assign chan_b_sample_bus_o = word_q.chan_b; // RQ5

  // one enable flop fans out to every pin of both buses
  genvar gb;
  generate
    for (gb = 0; gb < 8; gb++)
    begin : g_oe
      assign chan_a_sample_bus_oe_o[gb] = oe_q; // RQ4
      assign chan_b_sample_bus_oe_o[gb] = oe_q; // RQ4
    end
  endgenerate

  // ----------------------------------------
  // checks
  // ----------------------------------------
  oe_follow_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ4
    chan_a_sample_bus_oe_o == {8{~$past(ctrl_q.output_enable_n)}}
    && chan_b_sample_bus_oe_o == {8{~$past(ctrl_q.output_enable_n)}})
    else $error("bus enable does not follow the enable bit");

  sleep_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ2
    (ctrl_q.sleep && !ctrl_q.power_down_request) |=> $stable(word_q))
    else $error("sample words moved during sleep");

  pd_flush_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
    ctrl_q.power_down_request |=> pipe_pair == {daoc_pkg::MID_CODE, daoc_pkg::MID_CODE})
    else $error("power-down left a sample in the pipe");

  zero_code_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ8
    (update && pipe_pair.chan_a == daoc_pkg::MID_CODE)
    |=> chan_a_sample_bus_o == ($past(ctrl_q.fmt_twos) ? 8'h00 : 8'h80))
    else $error("bipolar zero took the wrong code on channel a");

  zero_code_b_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ8
    (update && pipe_pair.chan_b == daoc_pkg::MID_CODE)
    |=> chan_b_sample_bus_o == ($past(ctrl_q.fmt_twos) ? 8'h00 : 8'h80))
    else $error("bipolar zero took the wrong code on channel b");

  // only meaningful when every system clock is a converter tick
  latency_track_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ7
    (CONV_DIV == 1 && streak_q == STREAK_FULL)
    |-> raw_q == $past(quant_pair, LATENCY + 1))
    else $error("sample word left the pipe at the wrong latency");

  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack stood for more than one cycle");

  ack_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_req && !wb_ack_o) |=> wb_ack_o)
    else $error("ack did not follow the request");

  read_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$rose(wb_ack_o) |-> $stable(wb_dat_o))
    else $error("read data moved outside an answer");

  fmt_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
    (wr_fire && wb_sel_i[0] && adr_hit(wb_adr_i, daoc_pkg::CTRL_OFS))
    |=> ctrl_q.fmt_twos == $past(wb_dat_i[daoc_pkg::CTRL_FMT_BIT]))
    else $error("format bit did not take the written value");

  sleep_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ2
    (wr_fire && wb_sel_i[0] && adr_hit(wb_adr_i, daoc_pkg::CTRL_OFS))
    |=> ctrl_q.sleep == $past(wb_dat_i[daoc_pkg::CTRL_SLEEP_BIT]))
    else $error("sleep bit did not take the written value");

  pd_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
    (wr_fire && wb_sel_i[0] && adr_hit(wb_adr_i, daoc_pkg::CTRL_OFS))
    |=> ctrl_q.power_down_request == $past(wb_dat_i[daoc_pkg::CTRL_PD_BIT]))
    else $error("power-down bit did not take the written value");

  oen_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ4
    (wr_fire && wb_sel_i[0] && adr_hit(wb_adr_i, daoc_pkg::CTRL_OFS))
    |=> ctrl_q.output_enable_n == $past(wb_dat_i[daoc_pkg::CTRL_OEN_BIT]))
    else $error("enable bit did not take the written value");

endmodule // daoc_top

/* File: daoc_host.sv */
`timescale 1ns/1ps
module daoc_host (
  input wire logic clk_i,
  input wire logic [7:0] bus_i,
  input wire logic [7:0] oe_i,
  output logic [7:0] word_o
);
  // released bits flip each edge so a stale value never passes
  always_ff @(posedge clk_i)
  begin
    word_o <= (bus_i & oe_i) | (~word_o & ~oe_i);
  end
endmodule // daoc_host

/* File: daoc_top_tb.sv */
`timescale 1ns/1ps
module daoc_top_tb;
  localparam int LAT = daoc_pkg::LATENCY_CYCLES;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic drv = 1'b0;
  logic ack;
  logic [7:0] adr = 8'h00;
  logic [7:0] qa = 8'h00;
  logic [7:0] qb = 8'h00;
  logic [7:0] da, db, oea, oeb, ha, hb;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd;
  logic [31:0] r;
  logic [15:0] last = 16'h0;
  logic [LAT+1:0] live = '0;
  logic [15:0] notes[$];
  int n_errors = 0;
  int n_compared = 0;
  always #20 clk = ~clk;
  daoc_top dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .chan_a_quant_i(qa), .chan_b_quant_i(qb), .chan_a_sample_bus_o(da),
    .chan_a_sample_bus_oe_o(oea), .chan_b_sample_bus_o(db), .chan_b_sample_bus_oe_o(oeb));
  daoc_host host_a (.clk_i(clk), .bus_i(da), .oe_i(oea), .word_o(ha));
  daoc_host host_b (.clk_i(clk), .bus_i(db), .oe_i(oeb), .word_o(hb));
  task automatic chk_word(input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected word pair exp %h got %h", e, g);
    end
  endtask
  task automatic chk_reg(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic chk_pin(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (ack !== 1'b1 && ++t < 50);
    if (t >= 50) n_errors++;
    r = rd;
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask
  task automatic results();
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // a sample taken on one edge reaches the host latch latency plus one edges later
  task automatic stream(input logic f);
    logic [7:0] v;
    logic [7:0] w;
    wb(1'b1, daoc_pkg::CTRL_OFS, 32'(f));
    for (int k = 0; k < 16; k++)
    begin
      v = (k == 0) ? 8'h80 : (k == 1) ? 8'h00 : 8'($urandom);
      w = (k == 2) ? 8'hff : 8'($urandom);
      qa <= v;
      qb <= w;
      drv <= 1'b1;
      last = {f ? v ^ 8'h80 : v, f ? w ^ 8'h80 : w};
      notes.push_back(last);
      @(posedge clk);
    end
    drv <= 1'b0;
    repeat (LAT + 4) @(posedge clk);
  endtask
  always @(posedge clk) live <= {live[LAT:0], drv};
  // monitor: oldest note against both captured words when one is due
  always @(negedge clk)
  begin
    if (live[LAT + 1] && notes.size() > 0)
    begin
      chk_word(notes.pop_front(), {ha, hb});
      chk_pin("enable a", 8'hff, oea);
      chk_pin("enable b", 8'hff, oeb);
    end
    else if (live[LAT + 1])
      n_errors++;
  end
  initial
  begin
    repeat (2000) @(posedge clk);
    n_errors++;
    results();
  end
  initial
  begin
    void'($urandom(32'hcf91));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk_pin("enable after reset", 8'h00, oea);
    @(posedge clk);
    stream(1'b0);
    wb(1'b0, daoc_pkg::STAT_OFS, 32'h0);
    chk_reg("stat run", 32'h3, r);
    wb(1'b0, daoc_pkg::DATA_OFS, 32'h0);
    chk_reg("data", {16'h0, last[7:0], last[15:8]}, r);
    wb(1'b1, daoc_pkg::CTRL_OFS, 32'h2);
    wb(1'b0, daoc_pkg::STAT_OFS, 32'h0);
    chk_reg("stat sleep", 32'h5, r);
    qa <= 8'($urandom);
    qb <= 8'($urandom);
    repeat (LAT + 2) @(posedge clk);
    @(negedge clk);
    chk_pin("sleep a", last[15:8], da);
    chk_pin("sleep b", last[7:0], db);
    @(posedge clk);
    wb(1'b1, daoc_pkg::CTRL_OFS, 32'h5);
    wb(1'b0, daoc_pkg::STAT_OFS, 32'h0);
    chk_reg("stat power-down", 32'h9, r);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_pin("power-down a", 8'h00, da);
    chk_pin("power-down b", 8'h00, db);
    @(posedge clk);
    wb(1'b1, daoc_pkg::CTRL_OFS, 32'h4);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk_pin("offset zero a", 8'h80, da);
    chk_pin("offset zero b", 8'h80, db);
    @(posedge clk);
    stream(1'b1);
    wb(1'b0, daoc_pkg::STAT_OFS, 32'h0);
    chk_reg("stat resumed", 32'h3, r);
    wb(1'b1, daoc_pkg::CTRL_OFS, 32'h8);
    wb(1'b0, daoc_pkg::STAT_OFS, 32'h0);
    chk_reg("stat released", 32'h2, r);
    @(negedge clk);
    chk_pin("released a", 8'h00, oea);
    chk_pin("released b", 8'h00, oeb);
    @(posedge clk);
    wb(1'b0, 8'hf0, 32'h0);
    chk_reg("unmapped", 32'h0, r);
    wb(1'b1, daoc_pkg::CTRL_OFS, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk_pin("enable after second reset", 8'h00, oea);
    chk_reg("ack after reset", 32'h0, {31'h0, ack});
    @(posedge clk);
    wb(1'b0, daoc_pkg::CTRL_OFS, 32'h0);
    chk_reg("ctrl after reset", 32'h8, r);
    results();
  end
endmodule // daoc_top_tb
